// file: mbl_params.svh
/*
 mirror block load handshake: offsets, field positions, reset values
 and timing counts. assumes a 10 MHz system clock and is included by
 the package, the checker and the bench.
*/
`ifndef MBL_PARAMS_SVH
`define MBL_PARAMS_SVH

// register offsets (byte addresses)
`define MBL_OFS_STATUS 8'h00
`define MBL_OFS_IDENT 8'h04
`define MBL_OFS_VERSION 8'h08
`define MBL_OFS_INT_STATUS 8'h0C
`define MBL_OFS_INT_CLEAR 8'h10
`define MBL_OFS_INT_ENABLE 8'h14
`define MBL_OFS_CONTROL 8'h18
`define MBL_OFS_CTL_LOW 8'h1C
`define MBL_OFS_ROWS 8'h20

// interrupt bit positions
`define MBL_INT_STARTUP 0
`define MBL_INT_LOAD 1
`define MBL_INT_PULSE 2
`define MBL_INT_ORPHAN 3
`define MBL_INT_BITS 4

// control register fields and reset value
`define MBL_CTL_STRICT 0
`define MBL_CTL_RESTART 1
`define MBL_CTL_RESET 2'h1

// control word fields
`define MBL_OP_LSB 0
`define MBL_OP_BLOCK 2'h0
`define MBL_OP_ROW 2'h1
`define MBL_OP_NONE 2'h2

// timing, in picoseconds, and derived cycle counts
`define MBL_CLK_PS 100000
`define MBL_BLOCK_PS 5044440
`define MBL_ROWS 136
`define MBL_PULSE_PS 4000000
`define MBL_BLOCK_CYC ((`MBL_BLOCK_PS + `MBL_CLK_PS - 1) / `MBL_CLK_PS)
`define MBL_ROW_RAW \
	((`MBL_BLOCK_PS / `MBL_ROWS + `MBL_CLK_PS - 1) / `MBL_CLK_PS)
`define MBL_ROW_CYC ((`MBL_ROW_RAW < 1) ? 1 : `MBL_ROW_RAW)
`define MBL_PULSE_CYC ((`MBL_PULSE_PS + `MBL_CLK_PS - 1) / `MBL_CLK_PS)
`define MBL_INIT_CYC 64
`define MBL_CTL_BEATS 3

`endif

// file: mbl_pkg.sv
/*
 types of the mirror block load handshake. assumes mbl_params.svh
 sits in the same folder.
*/
`include "mbl_params.svh"

package mbl_pkg;
	typedef enum logic [1:0] {
		ST_CHECK,
		ST_SELECT,
		ST_INIT,
		ST_READY
	} mbl_start_t;

	typedef enum logic [1:0] {
		LD_IDLE,
		LD_RUN
	} mbl_load_t;

	// block select and pulse type travel together
	typedef struct packed {
		logic [3:0] block;
		logic [1:0] kind;
	} mbl_pulse_sel_t;

	// 192-bit control word, three 64-bit beats, first beat lowest
	typedef struct packed {
		logic [189:0] body;
		logic [1:0] op;
	} mbl_ctl_word_t;

	typedef struct packed {
		logic ctlPending;
		logic pulseActive;
		logic loadBusy;
		logic startDone;
		logic [1:0] startState;
	} mbl_status_t;
endpackage

// file: mbl_block_load.sv
/*
 mirror block load handshake of a micromirror array controller.
 assumes a 10 MHz system clock, a synchronous active-high reset and
 host pins that are asynchronous to that clock; the link clock is
 sampled like a pin and all link inputs are taken on its rising edge.
*/
// Overview of operation
// - startup complete only after array initialised
// - check array present, pick config, initialise
// - report init status, version, identity on query
// - control words on channels 1-3 ignored
// - load request ends block, runs word operation
// - busy held while word operation runs
// - block and pulse type choose mirror pulse
// - pulse active held for whole pulse
// - twelve serial links at 10Gbps each; code has one channel 0 beat port and four row lanes
// - block load 5.04444us, row is 1/136; code runs 51 cycles per block and 1 cycle (100 ns) per row
// - row split into four 1024-column segments
`timescale 1ns/100ps

module mbl_block_load
	import mbl_pkg::*;
#(
	parameter logic [31:0] IDENT_CODE = 32'h0000_5A5A, // arbitrary value
	parameter logic [31:0] VERSION_CODE = 32'h0001_0000,
	parameter int INIT_CYCLES = `MBL_INIT_CYC,
	parameter int ROWS_PER_BLOCK = `MBL_ROWS
) (
	// system
	input wire logic clock,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	output logic irq,
	// configuration status
	output logic configDone,
	output logic startupComplete,
	// mirror array presence and setup
	input wire logic arrayPresent,
	input wire logic [1:0] arrayType,
	output logic [1:0] arrayConfigSel,
	output logic arrayInitActive,
	// link clock and channel 0 control word beats
	input wire logic linkClock,
	input wire logic ctlBeatValid,
	input wire logic [63:0] ctlBeatData,
	// per-channel row completion on the data lanes
	input wire logic [3:0] segmentRowDone,
	// block control pins
	input wire logic [3:0] block_select,
	input wire logic [1:0] pulse_type_select,
	input wire logic block_load_request,
	input wire logic mirror_pulse_start,
	output logic block_loading_busy_n,
	output logic mirror_pulse_active,
	// mirror array pulse command
	output logic mirror_clock_pulse,
	output mbl_pulse_sel_t pulseSel
);

	localparam int BLOCK_CYC = `MBL_BLOCK_CYC;
	localparam int ROW_CYC = `MBL_ROW_CYC;
	localparam int PULSE_CYC = `MBL_PULSE_CYC;

	function automatic logic [7:0] opCycles(input logic [1:0] op);
		case (op)
			`MBL_OP_BLOCK: opCycles = 8'(BLOCK_CYC);
			`MBL_OP_ROW: opCycles = 8'(ROW_CYC);
			default: opCycles = 8'h01;
		endcase
	endfunction

	// two-flop synchronisers for every outside input except the register port and reset
	logic [3:0] syncA_reg, syncB_reg, syncC_reg;
	logic [5:0] selA_reg, selB_reg;
	logic [2:0] arrA_reg, arrB_reg;
	logic [4:0] linkA_reg, linkB_reg;
	logic [63:0] beatA_reg, beatB_reg;
	logic linkPrev_reg;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			syncA_reg <= 4'h0;
			syncB_reg <= 4'h0;
			syncC_reg <= 4'h0;
			selA_reg <= 6'h00;
			selB_reg <= 6'h00;
			arrA_reg <= 3'h0;
			arrB_reg <= 3'h0;
			linkA_reg <= 5'h00;
			linkB_reg <= 5'h00;
			beatA_reg <= 64'h0;
			beatB_reg <= 64'h0;
			linkPrev_reg <= 1'b0;
		end else begin
			syncA_reg <= {mirror_pulse_start, block_load_request,
				2'h0};
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
			selA_reg <= {block_select, pulse_type_select};
			selB_reg <= selA_reg;
			arrA_reg <= {arrayPresent, arrayType};
			arrB_reg <= arrA_reg;
			linkA_reg <= {linkClock, segmentRowDone};
			linkB_reg <= linkA_reg;
			beatA_reg <= ctlBeatData;
			beatB_reg <= beatA_reg;
			linkPrev_reg <= linkB_reg[4];
		end
	end

	logic linkEdge;
	logic loadReqEdge;
	logic pulseReqEdge;
	logic [1:0] ctlValidSync;
	assign linkEdge = linkB_reg[4] & ~linkPrev_reg;
	// held strobes: act on the rising edge only once
	assign loadReqEdge = syncB_reg[2] & ~syncC_reg[2];
	assign pulseReqEdge = syncB_reg[3] & ~syncC_reg[3];

	logic vA_reg, vB_reg;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			vA_reg <= 1'b0;
			vB_reg <= 1'b0;
		end else begin
			vA_reg <= ctlBeatValid;
			vB_reg <= vA_reg;
		end
	end
	assign ctlValidSync = {vB_reg, vB_reg};

	// registers written by software
	logic [1:0] control_reg;
	logic [`MBL_INT_BITS-1:0] intEnable_reg, intStatus_reg;
	logic [`MBL_INT_BITS-1:0] events;

	// startup sequence
	mbl_start_t start_reg;
	logic [15:0] initCount_reg;
	logic [1:0] configSel_reg;
	logic restartPulse;
	assign restartPulse = regWrite && regAddr == `MBL_OFS_CONTROL &&
		regWrData[`MBL_CTL_RESTART];

	always_ff @(posedge clock) begin
		if (sys_rst || restartPulse) begin
			start_reg <= ST_CHECK;
			initCount_reg <= 16'h0000;
			configSel_reg <= 2'h0;
		end else begin
			case (start_reg)
				ST_CHECK: begin
					if (arrB_reg[2])
						start_reg <= ST_SELECT;
				end
				ST_SELECT: begin
					configSel_reg <= arrB_reg[1:0];
					initCount_reg <= 16'h0000;
					start_reg <= ST_INIT;
				end
				ST_INIT: begin
					if (!arrB_reg[2])
						start_reg <= ST_CHECK;
					else if (initCount_reg == 16'(INIT_CYCLES - 1))
						start_reg <= ST_READY;
					else
						initCount_reg <= initCount_reg + 16'h0001;
				end
				ST_READY: start_reg <= ST_READY;
				default: start_reg <= ST_CHECK;
			endcase
		end
	end

	logic ready;
	assign ready = start_reg == ST_READY;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			configDone <= 1'b0;
			startupComplete <= 1'b0;
			arrayInitActive <= 1'b0;
			arrayConfigSel <= 2'h0;
		end else begin
			// logic runs from reset, so configuration is finished
			configDone <= 1'b1;
			startupComplete <= ready;
			arrayInitActive <= start_reg == ST_INIT;
			arrayConfigSel <= configSel_reg;
		end
	end

	// control word assembly, channel 0 only
	mbl_ctl_word_t ctlWord_reg;
	logic [1:0] beatIdx_reg;
	logic ctlPending_reg;
	logic beatTake;
	// only the channel 0 beat port exists: others never reach here
	assign beatTake = ready && linkEdge && ctlValidSync[0];

	mbl_load_t load_reg;
	logic [7:0] loadCount_reg;
	logic loadStart;
	logic loadDone;
	logic orphanReq;
	logic loadedOnce_reg;
	assign loadStart = load_reg == LD_IDLE && loadReqEdge &&
		(ctlPending_reg || !control_reg[`MBL_CTL_STRICT]);
	assign orphanReq = load_reg == LD_IDLE && loadReqEdge &&
		!ctlPending_reg;
	assign loadDone = load_reg == LD_RUN && loadCount_reg == 8'h01;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctlWord_reg <= '0;
			beatIdx_reg <= 2'h0;
			ctlPending_reg <= 1'b0;
		end else if (beatTake && load_reg == LD_IDLE) begin
			// a word opens a block; beats during a load are dropped and
			// a partial word continues on the first beat after load ends
			case (beatIdx_reg)
				2'h0: ctlWord_reg[63:0] <= beatB_reg;
				2'h1: ctlWord_reg[127:64] <= beatB_reg;
				default: ctlWord_reg[191:128] <= beatB_reg;
			endcase
			if (beatIdx_reg == 2'(`MBL_CTL_BEATS - 1)) begin
				beatIdx_reg <= 2'h0;
				ctlPending_reg <= 1'b1;
			end else begin
				beatIdx_reg <= beatIdx_reg + 2'h1;
				ctlPending_reg <= 1'b0;
			end
		end else if (loadStart) begin
			ctlPending_reg <= 1'b0;
		end
	end

	// row counters per data lane, cleared when a word opens a block
	logic [7:0] rows_reg [4];
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++)
				rows_reg[i] <= 8'h00;
		end else if (beatTake && beatIdx_reg == 2'h0) begin
			for (int i = 0; i < 4; i++)
				rows_reg[i] <= 8'h00;
		end else if (linkEdge && ctlPending_reg) begin
			// data counted only after the word is in
			for (int i = 0; i < 4; i++)
				if (linkB_reg[i] &&
					rows_reg[i] != 8'(ROWS_PER_BLOCK))
					rows_reg[i] <= rows_reg[i] + 8'h01;
		end
	end

	// block load operation
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			load_reg <= LD_IDLE;
			loadCount_reg <= 8'h00;
			loadedOnce_reg <= 1'b0;
		end else begin
			case (load_reg)
				LD_IDLE: begin
					if (loadStart) begin
						load_reg <= LD_RUN;
						loadCount_reg <= opCycles(ctlWord_reg.op);
					end
				end
				LD_RUN: begin
					if (loadDone) begin
						load_reg <= LD_IDLE;
						loadedOnce_reg <= 1'b1;
					end else
						loadCount_reg <= loadCount_reg - 8'h01;
				end
				default: load_reg <= LD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			block_loading_busy_n <= 1'b1;
		else
			block_loading_busy_n <= !(loadStart ||
				(load_reg == LD_RUN && !loadDone));
	end

	// mirror clock pulse
	logic [7:0] pulseCount_reg;
	logic pulseStart;
	logic pulseDone;
	assign pulseStart = !mirror_pulse_active && pulseReqEdge &&
		load_reg == LD_IDLE && loadedOnce_reg;
	assign pulseDone = mirror_pulse_active && pulseCount_reg == 8'h01;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mirror_pulse_active <= 1'b0;
			pulseCount_reg <= 8'h00;
			mirror_clock_pulse <= 1'b0;
			pulseSel <= '0;
		end else begin
			mirror_clock_pulse <= pulseStart;
			if (pulseStart) begin
				mirror_pulse_active <= 1'b1;
				pulseCount_reg <= 8'(PULSE_CYC);
				pulseSel <= {selB_reg[5:2], selB_reg[1:0]};
			end else if (pulseDone) begin
				mirror_pulse_active <= 1'b0;
			end else if (mirror_pulse_active) begin
				pulseCount_reg <= pulseCount_reg - 8'h01;
			end
		end
	end

	// interrupts: set wins over clear
	assign events[`MBL_INT_STARTUP] = ready && !startupComplete;
	assign events[`MBL_INT_LOAD] = loadDone;
	assign events[`MBL_INT_PULSE] = pulseDone;
	assign events[`MBL_INT_ORPHAN] = orphanReq;

	always_ff @(posedge clock) begin
		if (sys_rst)
			intStatus_reg <= '0;
		else if (regWrite && regAddr == `MBL_OFS_INT_CLEAR)
			intStatus_reg <= (intStatus_reg &
				~regWrData[`MBL_INT_BITS-1:0]) | events;
		else
			intStatus_reg <= intStatus_reg | events;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			intEnable_reg <= '0;
			control_reg <= `MBL_CTL_RESET;
		end else if (regWrite) begin
			if (regAddr == `MBL_OFS_INT_ENABLE)
				intEnable_reg <= regWrData[`MBL_INT_BITS-1:0];
			if (regAddr == `MBL_OFS_CONTROL)
				control_reg <= {1'b0, regWrData[`MBL_CTL_STRICT]};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(intStatus_reg & intEnable_reg);
	end

	// register reads, answered one cycle later
	mbl_status_t status;
	assign status = '{ctlPending: ctlPending_reg,
		pulseActive: mirror_pulse_active,
		loadBusy: !block_loading_busy_n,
		startDone: startupComplete,
		startState: start_reg};

	always_ff @(posedge clock) begin
		if (sys_rst)
			regRdData <= 32'h0;
		else if (regRead) begin
			case (regAddr)
				`MBL_OFS_STATUS: regRdData <= {26'h0, status};
				`MBL_OFS_IDENT: regRdData <= IDENT_CODE;
				`MBL_OFS_VERSION: regRdData <= VERSION_CODE;
				`MBL_OFS_INT_STATUS:
					regRdData <= {28'h0, intStatus_reg};
				`MBL_OFS_INT_ENABLE:
					regRdData <= {28'h0, intEnable_reg};
				`MBL_OFS_CONTROL: regRdData <= {30'h0, control_reg};
				`MBL_OFS_CTL_LOW: regRdData <= ctlWord_reg[31:0];
				`MBL_OFS_ROWS: regRdData <= {rows_reg[3], rows_reg[2],
					rows_reg[1], rows_reg[0]};
				default: regRdData <= 32'h0;
			endcase
		end else
			regRdData <= 32'h0;
	end

endmodule // mbl_block_load

// file: mbl_block_load_assertions.sv
/*
 pin checker of the block load handshake.
 assumes the ports of mbl_block_load and its params header.
*/
`timescale 1ns/100ps
`include "mbl_params.svh"
module mbl_block_load_chk
	import mbl_pkg::*;
(
	// system
	input wire logic clock,
	input wire logic sys_rst,
	// status
	input wire logic configDone,
	input wire logic startupComplete,
	// block control
	input wire logic [3:0] block_select,
	input wire logic [1:0] pulse_type_select,
	input wire logic block_load_request,
	input wire logic mirror_pulse_start,
	input wire logic block_loading_busy_n,
	input wire logic mirror_pulse_active,
	input wire logic mirror_clock_pulse,
	input wire mbl_pulse_sel_t pulseSel
);
	localparam int BLOCK_CYC = `MBL_BLOCK_CYC;
	localparam int PULSE_CYC = `MBL_PULSE_CYC;
	int busyCnt_reg;
	int pulseCnt_reg;
	// run lengths too long for a repetition operator
	always_ff @(posedge clock) begin
		busyCnt_reg <= (sys_rst || block_loading_busy_n) ? 0 : busyCnt_reg + 1;
	end
	always_ff @(posedge clock) begin
		pulseCnt_reg <= (sys_rst || !mirror_pulse_active) ? 0 : pulseCnt_reg + 1;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	a_busy_cause:
		assert property ($fell(block_loading_busy_n) |-> $past(block_load_request))
		else $error("busy without load request");
	a_busy_bound:
		assert property (busyCnt_reg <= BLOCK_CYC)
		else $error("busy longer than a block load");
	a_pulse_len:
		assert property ($fell(mirror_pulse_active) |-> pulseCnt_reg == PULSE_CYC)
		else $error("pulse active length wrong");
	a_pulse_clk:
		assert property ($rose(mirror_pulse_active) |-> mirror_clock_pulse)
		else $error("active without clock pulse");
	a_pulse_idle:
		assert property ($rose(mirror_pulse_active) |-> block_loading_busy_n)
		else $error("pulse started during load");
	a_pulse_cause:
		assert property (mirror_clock_pulse |-> $past(mirror_pulse_start) &&
			!$past(mirror_pulse_active))
		else $error("clock pulse without start");
	a_sel_capture:
		assert property (mirror_clock_pulse |->
			pulseSel == {$past(block_select), $past(pulse_type_select)})
		else $error("pulse select not captured");
	a_start_order:
		assert property (startupComplete |-> configDone)
		else $error("startup before configuration");
	c_load: cover property ($fell(block_loading_busy_n));
	c_pulse: cover property ($rose(mirror_pulse_active));
	c_start: cover property ($rose(startupComplete));
endmodule // mbl_block_load_chk

bind mbl_block_load mbl_block_load_chk chk (.*);

// file: mbl_host_model.sv
/*
 host model: channel 0 control beats and lane row marks.
 assumes the block samples linkClock with its own clock.
*/
`timescale 1ns/100ps
module mbl_host_model
	import mbl_pkg::*;
(
	// link pins
	output logic linkClock,
	output logic ctlBeatValid,
	output logic [63:0] ctlBeatData,
	output logic [3:0] segmentRowDone
);
	initial begin
		linkClock = 1'b0;
		ctlBeatValid = 1'b0;
		ctlBeatData = 64'h0;
		segmentRowDone = 4'h0;
	end
	// one 800 ns link period; the clock stands low between frames
	// a slow stand-in for one serial lane
	task automatic beat(input logic v, input logic [3:0] r, input logic [63:0] d);
		ctlBeatValid = v;
		ctlBeatData = d;
		segmentRowDone = r;
		#400 linkClock = 1'b1;
		#400 linkClock = 1'b0;
		// released data lines flip and valid and row marks drop to 0, so a held value is never mistaken for data
		ctlBeatValid = 1'b0;
		ctlBeatData = ~d;
		segmentRowDone = 4'h0;
	endtask
	// word goes first, channel 0 only, lowest beat first
	task automatic send_word(input logic [1:0] op);
		mbl_ctl_word_t w;
		w = {190'h1234_5678, op};
		for (int i = 0; i < 3; i++) begin
			beat(1'b1, 4'h0, w[i * 64 +: 64]);
		end
	endtask
	// rows on all four lanes, only after the word
	task automatic send_rows(input int n);
		for (int i = 0; i < n; i++) begin
			beat(1'b0, 4'hF, ~ctlBeatData);
		end
	endtask
endmodule // mbl_host_model

// file: tb_mbl_block_load.sv
/*
 bench of the block load handshake: register tasks and pin strobes.
 assumes mbl_host_model drives the link pins.
*/
`timescale 1ns/100ps
`include "mbl_params.svh"
module tb_mbl_block_load
	import mbl_pkg::*;
;
	localparam logic [31:0] IDC = 32'h0000_1234; // arbitrary value
	localparam logic [31:0] VERC = 32'h0002_0001;
	localparam int BLOCK_CYC = `MBL_BLOCK_CYC;
	localparam int PULSE_CYC = `MBL_PULSE_CYC;
	logic clock, sys_rst, regWrite, regRead, irq, configDone;
	logic startupComplete, arrayPresent, arrayInitActive, linkClock;
	logic ctlBeatValid, block_load_request, mirror_pulse_start;
	logic block_loading_busy_n, mirror_pulse_active, mirror_clock_pulse;
	logic [1:0] arrayType, arrayConfigSel, pulse_type_select;
	logic [3:0] segmentRowDone, block_select;
	logic [7:0] regAddr;
	logic [31:0] regWrData, regRdData;
	logic [63:0] ctlBeatData;
	mbl_pulse_sel_t pulseSel;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	// short init count keeps the run brief
	mbl_block_load #(.IDENT_CODE(IDC), .VERSION_CODE(VERC), .INIT_CYCLES(4))
		dut (.*);
	mbl_host_model host (.*);
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (failures == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		@(negedge clock);
		chk("read data", e, regRdData);
	endtask
	// strobe held until busy answers, then busy low cycles counted
	task automatic load(input int e);
		int n;
		n = 0;
		@(posedge clock);
		block_load_request <= 1'b1;
		for (int i = 0; i < 10 && block_loading_busy_n !== 1'b0; i++) begin
			@(posedge clock);
		end
		while (block_loading_busy_n === 1'b0 && n < 100) begin
			@(posedge clock);
			n++;
		end
		block_load_request <= 1'b0;
		chk("busy cycles", e, n);
	endtask
	task automatic pulse(input int e, input logic [5:0] sel);
		int n;
		n = 0;
		@(posedge clock);
		mirror_pulse_start <= 1'b1;
		for (int i = 0; i < 10 && mirror_clock_pulse !== 1'b1; i++) begin
			@(posedge clock);
		end
		if (e > 0) begin
			chk("pulse select", sel, pulseSel);
		end
		while (mirror_pulse_active === 1'b1 && n < 100) begin
			@(posedge clock);
			n++;
		end
		mirror_pulse_start <= 1'b0;
		chk("pulse cycles", e, n);
	endtask
	initial begin
		sys_rst = 1'b1;
		regAddr = 8'h00;
		regWrData = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		arrayPresent = 1'b1;
		arrayType = 2'h1;
		block_select = 4'h0;
		pulse_type_select = 2'h0;
		block_load_request = 1'b0;
		mirror_pulse_start = 1'b0;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		for (int i = 0; i < 300 && startupComplete !== 1'b1; i++) begin
			@(posedge clock);
		end
		chk("config done", 32'h1, configDone);
		chk("startup done", 32'h1, startupComplete);
		chk("config select", 32'h1, arrayConfigSel);
		chk("init active", 32'h0, arrayInitActive);
		rd(`MBL_OFS_IDENT, IDC);
		rd(`MBL_OFS_VERSION, VERC);
		rd(`MBL_OFS_STATUS, 32'h7);
		rd(`MBL_OFS_CONTROL, 32'h1);
		wr(`MBL_OFS_IDENT, 32'hFFFF_FFFF);
		rd(`MBL_OFS_IDENT, IDC);
		rd(8'h24, 32'h0);
		wr(`MBL_OFS_INT_ENABLE, 32'hF);
		rd(`MBL_OFS_INT_STATUS, 32'h1);
		chk("irq", 32'h1, irq);
		wr(`MBL_OFS_INT_CLEAR, 32'hF);
		// no load done yet, so the start is ignored
		pulse(0, 6'h0);
		// no word pending: strict mode refuses the strobe
		load(0);
		rd(`MBL_OFS_INT_STATUS, 32'h8);
		wr(`MBL_OFS_INT_ENABLE, 32'h0);
		repeat (2) @(posedge clock);
		chk("irq", 32'h0, irq);
		wr(`MBL_OFS_INT_CLEAR, 32'hF);
		// op codes block, row, none; a new word clears the row counts
		for (int k = 0; k < 3; k++) begin
			// keep link pin changes off the sampling edge
			@(negedge clock);
			host.send_word(2'(k));
			host.send_rows(2);
			repeat (4) @(posedge clock);
			rd(`MBL_OFS_STATUS, 32'h27);
			rd(`MBL_OFS_ROWS, 32'h0202_0202);
			load((k == 0) ? BLOCK_CYC : 1);
		end
		rd(`MBL_OFS_INT_STATUS, 32'h2);
		wr(`MBL_OFS_INT_CLEAR, 32'hF);
		for (int k = 0; k < 4; k++) begin
			block_select <= 4'(k * 5);
			pulse_type_select <= 2'(k);
			pulse(PULSE_CYC, {4'(k * 5), 2'(k)});
		end
		rd(`MBL_OFS_INT_STATUS, 32'h4);
		// loose mode runs the last word's no-op without a new word
		wr(`MBL_OFS_CONTROL, 32'h0);
		load(1);
		rd(`MBL_OFS_INT_STATUS, 32'hE);
		// restart drops startup complete, then startup runs again
		wr(`MBL_OFS_CONTROL, 32'h2);
		repeat (2) @(posedge clock);
		chk("restart", 32'h0, startupComplete);
		for (int i = 0; i < 300 && startupComplete !== 1'b1; i++) begin
			@(posedge clock);
		end
		chk("startup again", 32'h1, startupComplete);
		chk("config select", 32'h1, arrayConfigSel);
		rd(`MBL_OFS_INT_STATUS, 32'hF);
		give_verdict();
	end
endmodule // tb_mbl_block_load
